/* File: logic/qdsc_top.sv */
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module qdsc_top #(
    parameter logic [15:0] POR_CODE = 16'h0000
) (
    // clock and reset
    input  wire logic                              core_clk,
    input  wire logic                              sys_rst,
    // apb slave
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [7:0]                        paddr,
    input  wire logic [31:0]                       pwdata,
    output logic                                   pready,
    output logic [31:0]                            prdata,
    output logic                                   pslverr,
    // serial write port
    input  wire logic                              frame_select_n,
    input  wire logic                              sclk,
    input  wire logic                              din,
    // device pins
    input  wire logic                              load_strobe_n,
    input  wire logic                              gio_in,
    output logic                                   gio_out,
    output logic                                   gio_oe,
    // converter side
    output logic [qdsc_pkg::CH_COUNT*16-1:0]       dac_code,
    output logic [qdsc_pkg::CH_COUNT*2-1:0]        pd_mode,
    output logic                                   chain_enable,
    output logic                                   frame_done
);

    // synchroniser chains: [0] first stage, [1] clean, [2] previous
    logic [2:0] fs_q;
    logic [2:0] sc_q;
    logic [2:0] di_q;
    logic [2:0] ld_q;
    logic [1:0] gi_q;

    // frame engine state
    qdsc_pkg::qdsc_state_e st_q, st_d;
    logic [4:0]            cnt_q, cnt_d;
    logic [31:0]           sh_q, sh_d;
    logic                  exec;

    // device state
    qdsc_pkg::qdsc_dev_s dev_q, dev_d;
    logic [31:0]         last_q, last_d;
    logic [7:0]          frames_q, frames_d;
    logic                done_q, done_d;

    // apb state
    logic [1:0]  cfg_q, cfg_d;
    logic        pready_q, pready_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pslverr_q, pslverr_d;
    logic        apb_srst;

    // decode helpers
    qdsc_pkg::qdsc_word_s          wd;
    logic [qdsc_pkg::CH_COUNT-1:0] sel;
    logic                          sclk_fall;
    logic                          fs_fall;
    logic                          ld_fall;

    // power-on contents, also used by soft reset
    function automatic qdsc_pkg::qdsc_dev_s por_state();
        qdsc_pkg::qdsc_dev_s s;
        s = '0;
        for (int i = 0; i < qdsc_pkg::CH_COUNT; i++) begin
            s.in_code[i] = POR_CODE;
            s.dac_code[i] = POR_CODE;
        end
        return s;
    endfunction : por_state

    // channel_select_field to channel mask
    function automatic logic [qdsc_pkg::CH_COUNT-1:0] chan_sel(input logic [3:0] a);
        logic [qdsc_pkg::CH_COUNT-1:0] m;
        m = '0;
        if (a == qdsc_pkg::ADDR_ALL) begin
            m = '1; // R9
        end else if (int'(a) < qdsc_pkg::CH_ADDRESSABLE) begin
            m[a[1:0]] = 1'b1; // R9
        end
        return m;
    endfunction : chan_sel

    // every pin input passes two flops before use
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fs_q <= 3'h7;
            sc_q <= 3'h7;
            di_q <= 3'h0;
            ld_q <= 3'h7;
            gi_q <= 2'h0;
        end else begin
            fs_q <= {fs_q[1:0], frame_select_n};
            sc_q <= {sc_q[1:0], sclk};
            di_q <= {di_q[1:0], din};
            ld_q <= {ld_q[1:0], load_strobe_n};
            gi_q <= {gi_q[0], gio_in};
        end
    end

    // edges seen on the clean stages only
    assign sclk_fall = sc_q[2] & ~sc_q[1];
    assign fs_fall = fs_q[2] & ~fs_q[1];
    assign ld_fall = ld_q[2] & ~ld_q[1];

    // frame engine: open, shift, execute, wait for release
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        exec = 1'b0;
        unique case (st_q)
            qdsc_pkg::ST_IDLE: begin
                // a low level alone opens no frame, unless it is already low as sys_rst is released
                if (cfg_q[qdsc_pkg::CFG_EN_BIT] && fs_fall) begin // R1
                    st_d = qdsc_pkg::ST_SHIFT;
                    cnt_d = '0;
                    sh_d = '0;
                end
            end
            qdsc_pkg::ST_SHIFT: begin
                if (fs_q[1]) begin
                    st_d = qdsc_pkg::ST_IDLE; // R20
                    cnt_d = '0;
                    sh_d = '0;
                end else if (sclk_fall) begin
                    // di_q[2] is din as it stood just before the fall
                    sh_d = {sh_q[30:0], di_q[2]}; // R2 R18
                    cnt_d = 5'(cnt_q + 5'h01);
                    if (cnt_q == qdsc_pkg::LAST_BIT) begin
                        exec = 1'b1; // R3
                        st_d = qdsc_pkg::ST_DONE;
                    end
                end
            end
            qdsc_pkg::ST_DONE: begin
                // extra edges while still low are ignored
                if (fs_q[1]) begin
                    st_d = qdsc_pkg::ST_IDLE; // R4
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_q <= qdsc_pkg::ST_IDLE;
            cnt_q <= '0;
            sh_q <= '0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
        end
    end

    // command decoder, acting on the word completed this cycle
    always_comb begin
        dev_d = dev_q;
        last_d = last_q;
        frames_d = frames_q;
        done_d = exec;
        wd = qdsc_pkg::qdsc_word_s'(sh_d); // R7 R10
        sel = chan_sel(wd.addr);
        // hardware strobe loads channels not masked off
        if (ld_fall) begin
            for (int i = 0; i < qdsc_pkg::CH_COUNT; i++) begin
                if (!dev_q.ld_mask[i]) begin
                    dev_d.dac_code[i] = dev_q.in_code[i];
                end
            end
        end
        if (exec) begin
            last_d = sh_d;
            frames_d = 8'(frames_q + 8'h01);
            if (!wd.cmd[3]) begin // R8 R19
                unique case (wd.cmd[2:0])
                    qdsc_pkg::OP_WR_IN: begin
                        for (int i = 0; i < qdsc_pkg::CH_COUNT; i++) begin
                            if (sel[i]) dev_d.in_code[i] = wd.code; // R11
                        end
                    end
                    qdsc_pkg::OP_UPD: begin
                        for (int i = 0; i < qdsc_pkg::CH_COUNT; i++) begin
                            if (sel[i]) dev_d.dac_code[i] = dev_q.in_code[i]; // R12
                        end
                    end
                    qdsc_pkg::OP_WR_LOAD_ALL: begin
                        for (int i = 0; i < qdsc_pkg::CH_COUNT; i++) begin
                            if (sel[i]) begin
                                dev_d.in_code[i] = wd.code; // R11
                            end
                            dev_d.dac_code[i] = dev_d.in_code[i]; // R11
                        end
                    end
                    qdsc_pkg::OP_WR_UPD: begin
                        for (int i = 0; i < qdsc_pkg::CH_COUNT; i++) begin
                            if (sel[i]) begin
                                dev_d.in_code[i] = wd.code; // R13
                                dev_d.dac_code[i] = wd.code; // R13
                            end
                        end
                    end
                    qdsc_pkg::OP_POWER: begin
                        // channel picks come from the low data bits
                        for (int i = 0; i < qdsc_pkg::CH_COUNT; i++) begin
                            if (sh_d[i]) begin
                                dev_d.pd_mode[i] = sh_d[qdsc_pkg::PD_LSB +: 2]; // R14 R22
                            end
                        end
                    end
                    qdsc_pkg::OP_CLR_CODE: begin
                        dev_d.clr_code = sh_d[1:0]; // R15
                    end
                    qdsc_pkg::OP_LD_MASK: begin
                        dev_d.ld_mask = sh_d[qdsc_pkg::CH_COUNT-1:0]; // R15
                    end
                    qdsc_pkg::OP_SW_RESET: begin
                        dev_d = por_state(); // R14 R21
                    end
                endcase
            end else begin
                case (wd.cmd[2:0])
                    qdsc_pkg::OP_CHAIN: begin
                        dev_d.chain_en = (sh_d[1:0] == qdsc_pkg::CHAIN_ON); // R16 R23
                    end
                    qdsc_pkg::OP_GIO: begin
                        dev_d.io_dir = sh_d[qdsc_pkg::GIO_DIR_BIT]; // R17
                        dev_d.io_val = sh_d[qdsc_pkg::GIO_VAL_BIT]; // R17
                    end
                    default: begin
                        // nothing moves, so a same-cycle strobe load is kept // R17
                    end
                endcase
            end
        end
        // software reset from the bus overrides a same-cycle frame
        if (apb_srst) begin
            dev_d = por_state();
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dev_q <= por_state();
            last_q <= '0;
            frames_q <= '0;
            done_q <= 1'b0;
        end else begin
            dev_q <= dev_d;
            last_q <= last_d;
            frames_q <= frames_d;
            done_q <= done_d;
        end
    end

    // apb slave: data and ready prepared in setup, so no wait states
    always_comb begin
        cfg_d = cfg_q;
        pready_d = 1'b0;
        prdata_d = '0;
        pslverr_d = 1'b0;
        apb_srst = 1'b0;
        if (psel && !penable) begin
            pready_d = 1'b1;
            case (paddr)
                qdsc_pkg::OFF_CFG: begin
                    prdata_d[1:0] = {1'b0, cfg_q[qdsc_pkg::CFG_EN_BIT]};
                end
                qdsc_pkg::OFF_STATUS: begin
                    prdata_d[4:0] = {gi_q[1], dev_q.io_val, dev_q.io_dir,
                                     dev_q.chain_en, st_q == qdsc_pkg::ST_SHIFT};
                    prdata_d[qdsc_pkg::ST_FRAMES_LSB +: 8] = frames_q;
                end
                qdsc_pkg::OFF_LAST: begin
                    prdata_d = last_q;
                end
                qdsc_pkg::OFF_MASKS: begin
                    prdata_d[qdsc_pkg::CH_COUNT-1:0] = dev_q.ld_mask;
                    prdata_d[9:8] = dev_q.clr_code;
                end
                qdsc_pkg::OFF_POWER: begin
                    prdata_d[qdsc_pkg::CH_COUNT*2-1:0] = dev_q.pd_mode;
                end
                default: begin
                    if (paddr[7:4] == qdsc_pkg::OFF_CH_HI && paddr[1:0] == 2'h0) begin
                        prdata_d = {dev_q.in_code[paddr[3:2]], dev_q.dac_code[paddr[3:2]]};
                    end else begin
                        pslverr_d = 1'b1;
                    end
                end
            endcase
            // only the config word is writable
            if (pwrite && paddr != qdsc_pkg::OFF_CFG) begin
                pslverr_d = 1'b1;
            end
            if (pwrite) begin
                prdata_d = '0;
            end
        end
        if (psel && penable && pready_q && pwrite && paddr == qdsc_pkg::OFF_CFG) begin
            cfg_d[qdsc_pkg::CFG_EN_BIT] = pwdata[qdsc_pkg::CFG_EN_BIT];
            apb_srst = pwdata[qdsc_pkg::CFG_SRST_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cfg_q <= qdsc_pkg::CFG_RST;
            pready_q <= 1'b0;
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            pready_q <= pready_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // outputs straight from flops
    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign gio_out = dev_q.io_val;
    assign gio_oe = dev_q.io_dir;
    assign dac_code = dev_q.dac_code;
    assign pd_mode = dev_q.pd_mode;
    assign chain_enable = dev_q.chain_en;
    assign frame_done = done_q;

endmodule : qdsc_top
`default_nettype wire

/* File: include/qdsc_pkg.sv */
// Behaviour
// R1: a frame opens only on a falling edge of frame_select_n.
// R2: while framed, din is shifted in on each falling sclk edge.
// R3: the 32nd falling edge captures the last bit and runs the command.
// R4: after execution, frame_select_n may stay low or rise; both are fine.
// R5: host keeps frame_select_n high at least 15 ns between frames.
// R6: host may idle frame_select_n low, but raises it before each frame.
// R7: the top four bits of the word are ignored.
// R8: the next four bits are the command_field.
// R9: channel_select_field: 0000 first, 0001 second, 0010/0011 reserved, 1111 all.
// R10: last twenty bits are a 16-bit code then four ignored bits.
// R11: 000 writes input register; 010 writes it then updates all DACs.
// R12: 001 copies the addressed input register into its DAC register.
// R13: 011 writes the input register and updates that DAC register.
// R14: 100 sets per-channel power state; 111 in group one is soft reset.
// R15: 101 loads the clear code; 110 loads the load_strobe_n mask.
// R16: second group 000 writes the chain_enable setup register.
// R17: second group 001 sets general_io_pin; 111 is reserved, no effect.
// R18: bits arrive most significant first into the top of the register.
// R19: top command bit clear is group one, set is group two.
// R20: frame_select_n rising before the 32nd edge discards the frame.
// R21: code 0111 resets everything to the power-on state.
// R22: code 0100 powers selected channels down or up.
// R23: chain_enable defaults standalone; setup bits 1,0 select daisy chain.
package qdsc_pkg;

    localparam int CH_COUNT = 4;
    localparam int CH_ADDRESSABLE = 2;
    localparam int WORD_W = 32;
    localparam logic [4:0] LAST_BIT = 5'h1f;

    // command low bits, group one
    localparam logic [2:0] OP_WR_IN = 3'h0;
    localparam logic [2:0] OP_UPD = 3'h1;
    localparam logic [2:0] OP_WR_LOAD_ALL = 3'h2;
    localparam logic [2:0] OP_WR_UPD = 3'h3;
    localparam logic [2:0] OP_POWER = 3'h4;
    localparam logic [2:0] OP_CLR_CODE = 3'h5;
    localparam logic [2:0] OP_LD_MASK = 3'h6;
    localparam logic [2:0] OP_SW_RESET = 3'h7;
    // command low bits, group two
    localparam logic [2:0] OP_CHAIN = 3'h0;
    localparam logic [2:0] OP_GIO = 3'h1;

    localparam logic [3:0] ADDR_ALL = 4'hf;
    localparam logic [1:0] CHAIN_ON = 2'h2;
    localparam int PD_LSB = 8;
    localparam int GIO_DIR_BIT = 1;
    localparam int GIO_VAL_BIT = 0;

    // apb byte offsets
    localparam logic [7:0] OFF_CFG = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_LAST = 8'h08;
    localparam logic [7:0] OFF_MASKS = 8'h0c;
    localparam logic [7:0] OFF_POWER = 8'h20;
    localparam logic [3:0] OFF_CH_HI = 4'h1;
    localparam logic [1:0] CFG_RST = 2'h1;
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_SRST_BIT = 1;
    localparam int ST_FRAMES_LSB = 8;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE  = 3'b100
    } qdsc_state_e;

    typedef struct packed {
        logic [3:0]  pad;
        logic [3:0]  cmd;
        logic [3:0]  addr;
        logic [15:0] code;
        logic [3:0]  tail;
    } qdsc_word_s;

    typedef struct packed {
        logic [CH_COUNT-1:0][15:0] in_code;
        logic [CH_COUNT-1:0][15:0] dac_code;
        logic [CH_COUNT-1:0][1:0]  pd_mode;
        logic [CH_COUNT-1:0]       ld_mask;
        logic [1:0]                clr_code;
        logic                      chain_en;
        logic                      io_dir;
        logic                      io_val;
    } qdsc_dev_s;

endpackage : qdsc_pkg

/* File: test/qdsc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module qdsc_host_model (
    // serial lines towards the device
    output logic frame_select_n,
    output logic sclk,
    output logic din
);
    // idle: frame high, clock standing high
    initial begin
        frame_select_n = 1'h1;
        sclk = 1'h1;
        din = 1'h0;
    end

    // one frame msb first; fewer than 32 bits cuts it short
    task automatic send(input logic [31:0] w, input int n);
        // offset keeps every pin change clear of the core clock edge
        #10 frame_select_n = 1'h1;
        #120;
        frame_select_n = 1'h0;
        #160;
        for (int i = 0; i < n; i++) begin
            din = w[31-i];
            #160 sclk = 1'h0;
            #160 sclk = 1'h1;
        end
        #160;
        // idle low after full frames, saves power on a real part
        if (n < 32)
            frame_select_n = 1'h1;
        din = ~din; // stale data never looks valid
    endtask : send
endmodule : qdsc_host_model
`default_nettype wire

/* File: test/qdsc_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module qdsc_properties #(
    parameter logic [15:0] POR_CODE = 16'h0000
) (
    // clock and reset
    input wire logic                        core_clk,
    input wire logic                        sys_rst,
    // apb
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [7:0]                  paddr,
    input wire logic                        pready,
    input wire logic [31:0]                 prdata,
    input wire logic                        pslverr,
    // serial and outputs
    input wire logic                        frame_select_n,
    input wire logic [qdsc_pkg::CH_COUNT*16-1:0] dac_code,
    input wire logic [qdsc_pkg::CH_COUNT*2-1:0]  pd_mode,
    input wire logic                        chain_enable,
    input wire logic                        gio_oe,
    input wire logic                        frame_done
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // apb answers wait-free, one cycle
    AST_APB_READY: assert property (psel && !penable |=> pready)
        else $error("no ready in access phase");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access");
    AST_WR_ERR: assert property (psel && !penable && pwrite && paddr != 8'h00 |=> pslverr)
        else $error("bad write not refused");
    // command execution pulse
    AST_DONE_PULSE: assert property (frame_done |=> !frame_done)
        else $error("done longer than a cycle");
    AST_NO_FRAME: assert property (frame_select_n [*8] |=> !frame_done)
        else $error("done without a frame");
    // mode outputs move only on a command or a config write
    AST_PD_CAUSE: assert property (!$stable(pd_mode) |->
        frame_done || $past(psel && pwrite) || $past(psel && pwrite, 2))
        else $error("power mode moved alone");
    AST_CHAIN_CAUSE: assert property (!$stable(chain_enable) |->
        frame_done || $past(psel && pwrite) || $past(psel && pwrite, 2))
        else $error("chain moved alone");
    AST_GIO_CAUSE: assert property (!$stable(gio_oe) |->
        frame_done || $past(psel && pwrite) || $past(psel && pwrite, 2))
        else $error("io enable moved alone");
    AST_POR: assert property ($fell(sys_rst) |->
        dac_code == {qdsc_pkg::CH_COUNT{POR_CODE}} && pd_mode == 8'h00 && !chain_enable)
        else $error("wrong reset state");
endmodule : qdsc_properties

bind qdsc_top qdsc_properties #(.POR_CODE(POR_CODE)) i_props (
    .core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pready, .prdata,
    .pslverr, .frame_select_n, .dac_code, .pd_mode, .chain_enable, .gio_oe,
    .frame_done);
`default_nettype wire

/* File: test/quad_dac_serial_command_port_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module quad_dac_serial_command_port_bench;
    localparam logic [15:0] POR = 16'h1234;
    logic        core_clk = 1'h0;
    logic        sys_rst = 1'h1;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        load_strobe_n = 1'h1;
    logic        gio_in = 1'h0;
    logic        pready, pslverr, gio_out, gio_oe, chain_enable, frame_done;
    logic [31:0] prdata, rdv;
    logic [63:0] dac_code;
    logic [7:0]  pd_mode;
    logic        er;
    wire         frame_select_n, sclk, din;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          done_n = 0;

    // 25 MHz core clock
    always #20 core_clk = ~core_clk;

    qdsc_top #(.POR_CODE(POR)) i_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .frame_select_n(frame_select_n),
        .sclk(sclk), .din(din), .load_strobe_n(load_strobe_n), .gio_in(gio_in),
        .gio_out(gio_out), .gio_oe(gio_oe), .dac_code(dac_code), .pd_mode(pd_mode),
        .chain_enable(chain_enable), .frame_done(frame_done));

    qdsc_host_model i_host (.frame_select_n(frame_select_n), .sclk(sclk), .din(din));

    // count executed commands
    always @(posedge core_clk) begin
        if (frame_done === 1'h1)
            done_n++;
    end

    task chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one apb transfer, entered just after a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            finish_test();
        end
        rdv = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge core_clk);
    endtask : apb

    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0000_0000);
        chk("prdata", rdv, e);
    endtask : rd

    function automatic logic [31:0] mk(input logic [3:0] c, input logic [3:0] a,
                                       input logic [19:0] lo);
        return {4'hf, c, a, lo}; // ignored prefix set on purpose
    endfunction : mk

    // send a frame and see whether one command ran for a full frame, none for a cut one
    task frame(input logic [31:0] w, input int n);
        int c;
        c = done_n;
        i_host.send(w, n);
        repeat (12) @(posedge core_clk);
        chk("frame_done", done_n - c, (n == 32) ? 1 : 0);
    endtask : frame

    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    // main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'h0;
        @(posedge core_clk);
        chk("dac_code", dac_code, {4{POR}});
        rd(8'h00, 32'h0000_0001);
        frame(mk(4'h0, 4'h0, {16'ha5c3, 4'hf}), 32);
        chk("dac_code", dac_code, {4{POR}});
        rd(8'h10, {16'ha5c3, POR});
        frame(mk(4'h1, 4'h0, {16'hffff, 4'hf}), 32);
        chk("dac_code", dac_code, {POR, POR, POR, 16'ha5c3});
        frame(mk(4'h3, 4'h1, {16'h5a3c, 4'h0}), 32);
        chk("dac_code", dac_code, {POR, POR, 16'h5a3c, 16'ha5c3});
        frame(mk(4'h2, 4'h0, {16'h0f0f, 4'h0}), 32);
        chk("dac_code", dac_code, {POR, POR, 16'h5a3c, 16'h0f0f});
        // reserved channel codes touch nothing
        for (int k = 2; k < 4; k++) begin
            frame(mk(4'h3, k[3:0], {16'h7777, 4'h0}), 32);
        end
        chk("dac_code", dac_code, {POR, POR, 16'h5a3c, 16'h0f0f});
        frame(mk(4'h3, 4'hf, {16'hbeef, 4'h0}), 32);
        chk("dac_code", dac_code, {4{16'hbeef}});
        // cut at the last bit, then a fresh frame still works
        frame(mk(4'h3, 4'h0, {16'h1111, 4'h0}), 31);
        chk("dac_code", dac_code, {4{16'hbeef}});
        frame(mk(4'h4, 4'h0, 20'h0_0205), 32);
        chk("pd_mode", pd_mode, 8'h22);
        frame(mk(4'h5, 4'h0, 20'h0_0003), 32);
        frame(mk(4'h6, 4'h0, 20'h0_0005), 32);
        rd(8'h0c, 32'h0000_0305);
        frame(mk(4'h8, 4'h0, 20'h0_0002), 32);
        chk("chain_enable", chain_enable, 1'h1);
        frame(mk(4'h9, 4'h0, 20'h0_0003), 32);
        chk("gio", {gio_oe, gio_out}, 2'h3);
        // second group lookalikes of data writes, and the reserved code
        frame(mk(4'hb, 4'hf, 20'h0_0000), 32);
        frame(mk(4'hf, 4'hf, 20'h0_0000), 32);
        chk("dac_code", dac_code, {4{16'hbeef}});
        chk("state", {chain_enable, gio_oe, gio_out, pd_mode}, 11'h722);
        // strobe pin loads only channels whose mask bit is clear
        frame(mk(4'h0, 4'hf, {16'h4321, 4'h0}), 32);
        load_strobe_n <= 1'h0;
        repeat (4) @(posedge core_clk);
        load_strobe_n <= 1'h1;
        repeat (4) @(posedge core_clk);
        chk("dac_code", dac_code, {16'h4321, 16'hbeef, 16'h4321, 16'hbeef});
        frame(mk(4'h7, 4'h0, 20'h0_0000), 32);
        chk("dac_code", dac_code, {4{POR}});
        chk("state", {chain_enable, gio_oe, gio_out, pd_mode}, 11'h000);
        rd(8'h0c, 32'h0000_0000);
        // bus soft reset brings back the power-on codes, port stays on
        frame(mk(4'h3, 4'hf, {16'hbeef, 4'h0}), 32);
        apb(1'h1, 8'h00, 32'h0000_0003);
        chk("pslverr", er, 1'h0);
        chk("dac_code", dac_code, {4{POR}});
        rd(8'h00, 32'h0000_0001);
        // refused accesses
        apb(1'h1, 8'h04, 32'h0000_0001);
        chk("pslverr", er, 1'h1);
        apb(1'h0, 8'h40, 32'h0000_0000);
        chk("pslverr", er, 1'h1);
        finish_test();
    end
endmodule : quad_dac_serial_command_port_bench
`default_nettype wire
